// File: rtl/pcs_pkg.sv
// pcs_pkg: constants shared by the serial configuration slave and its bus master
// assumes nothing beyond a SystemVerilog compiler
package pcs_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h65;
  localparam int DUMMY_BYTES = 2;
  localparam int CFG_BYTES = 3;
  localparam int BYP_BIT = 7;
  localparam int SEL_BIT = 6;
  localparam int REF_MSB = 5;
  localparam logic [7:0] CFG0_RESET = 8'h00;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [9:0] FB_OFFSET = 10'h003;
  localparam logic [6:0] REF_OFFSET = 7'h02;
  localparam logic [9:0] PIN_MULT_LOW = 10'h010;
  localparam logic [9:0] PIN_MULT_HIGH = 10'h008;
  localparam int LINK_HALF_CYCLES = 4;
endpackage : pcs_pkg

// File: rtl/pcs_link_if.sv
// pcs_link_if: two-wire link between master and slave
// assumes an external pull-up: a line is low when any enable is low
`timescale 1ns/10ps
interface pcs_link_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_s_out;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  assign scl = ~(~scl_oe_n & ~scl_out);
  assign sda = ~((~sda_m_oe_n & ~sda_m_out) | (~sda_s_oe_n & ~sda_s_out));
  modport master (output scl_out, output scl_oe_n, output sda_m_out, output sda_m_oe_n,
    input scl, input sda);
  modport slave (output sda_s_out, output sda_s_oe_n, input scl, input sda);
endinterface : pcs_link_if

// File: rtl/pcs_master.sv
// pcs_master: bus master that writes or reads the configuration bytes
// assumes the slave end on the same interface and a pulled-up link
`timescale 1ns/10ps
module pcs_master #(
  parameter int HALF = pcs_pkg::LINK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic start_in,
  input wire logic read_in,
  input wire logic [6:0] addr_in,
  input wire logic [2:0] nbytes_in,
  input wire logic [39:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic nack_out,
  output logic [39:0] rdata_out,
  pcs_link_if.master link
);
  typedef enum logic [2:0] {
    PM_IDLE = 3'b000, PM_START = 3'b001, PM_BIT = 3'b011, PM_ACK = 3'b010,
    PM_STOP = 3'b110, PM_END = 3'b111
  } pm_state_t;
  pm_state_t st_q;
  logic [15:0] tick_q;
  logic [1:0] ph_q;
  logic [2:0] bit_q;
  logic [2:0] byte_q;
  logic [2:0] nb_q;
  logic rd_q;
  logic [7:0] sh_q;
  logic [47:0] buf_q;
  logic [1:0] sda_s_q;
  logic tick;
  assign tick = (tick_q == 16'(HALF - 1));
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_s_q <= 2'h3;
    end else if (en_in) begin
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_q <= 16'h0000;
    end else if (en_in) begin
      tick_q <= (st_q == PM_IDLE || tick) ? 16'h0000 : tick_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= PM_IDLE;
      ph_q <= 2'h0;
      bit_q <= 3'h0;
      byte_q <= 3'h0;
      nb_q <= 3'h0;
      rd_q <= 1'b0;
      sh_q <= 8'h00;
      buf_q <= 48'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      rdata_out <= 40'h0;
      link.scl_out <= 1'b0;
      link.scl_oe_n <= 1'b1;
      link.sda_m_out <= 1'b0;
      link.sda_m_oe_n <= 1'b1;
    end else if (en_in) begin
      done_out <= 1'b0;
      unique case (st_q)
        PM_IDLE: begin
          link.scl_oe_n <= 1'b1;
          link.sda_m_oe_n <= 1'b1;
          if (start_in) begin
            busy_out <= 1'b1;
            nack_out <= 1'b0;
            rd_q <= read_in;
            nb_q <= nbytes_in;
            buf_q <= {addr_in, read_in, wdata_in};
            byte_q <= 3'h0;
            ph_q <= 2'h0;
            st_q <= PM_START;
          end
        end
        PM_START: if (tick) begin
          link.sda_m_oe_n <= 1'b0;
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h1) begin
            link.scl_oe_n <= 1'b0;
            sh_q <= buf_q[47:40];
            bit_q <= 3'h0;
            ph_q <= 2'h0;
            st_q <= PM_BIT;
          end
        end
        PM_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            link.sda_m_oe_n <= (rd_q && byte_q != 3'h0) ? 1'b1 : sh_q[7];
          end else if (ph_q == 2'h1) begin
            link.scl_oe_n <= 1'b1;
          end else begin
            link.scl_oe_n <= 1'b0;
            sh_q <= {sh_q[6:0], sda_s_q[1]};
            ph_q <= 2'h0;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) st_q <= PM_ACK;
          end
        end
        PM_ACK: if (tick) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            // master acks read bytes except the last
            link.sda_m_oe_n <= ~(rd_q && byte_q != 3'h0 && byte_q != nb_q);
            if (rd_q && byte_q != 3'h0) rdata_out <= {rdata_out[31:0], sh_q};
          end else if (ph_q == 2'h1) begin
            link.scl_oe_n <= 1'b1;
          end else begin
            link.scl_oe_n <= 1'b0;
            ph_q <= 2'h0;
            bit_q <= 3'h0;
            buf_q <= {buf_q[39:0], 8'h00};
            sh_q <= buf_q[39:32];
            byte_q <= byte_q + 3'h1;
            if ((!rd_q || byte_q == 3'h0) && sda_s_q[1]) begin
              nack_out <= 1'b1;
              st_q <= PM_STOP;
            end else if (byte_q == nb_q) begin
              st_q <= PM_STOP;
            end else begin
              st_q <= PM_BIT;
            end
          end
        end
        PM_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) begin
            link.sda_m_oe_n <= 1'b0;
          end else if (ph_q == 2'h1) begin
            link.scl_oe_n <= 1'b1;
          end else begin
            link.sda_m_oe_n <= 1'b1;
            st_q <= PM_END;
          end
        end
        PM_END: if (tick) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          st_q <= PM_IDLE;
        end
        default: st_q <= PM_IDLE;
      endcase
    end
  end
endmodule : pcs_master

// File: rtl/pcs_slave.sv
// pcs_slave: serial configuration slave and static pin decode of the clock generator
// assumes scl/sda from the pulled-up link; pins are asynchronous to clk_in
//
// Summary of operation
// - only the master drives the clock
// - sda fall with scl high starts transfer
// - sda rise with scl high stops, idle
// - data changes only while clock low
// - ack low across whole clock high
// - address plus direction, then eight-bit bytes
// - ack own address, else release data
// - direction zero writes, one reads
// - receiver acknowledges every byte; here the master does not ack the last read byte
// - slave address is 1100101
// - two dummy bytes are discarded
// - three bytes stored, extras acked, ignored
// - byte0 bypass, select, ref code; byte1 feedback
// - select resets low, high enables serial codes
// - feedback (code+3)*2, reference code+2
// - bypass resets low, forces reference one
// - select low uses multiplier pin
// - pin low times sixteen, high eight
// - bank a halves when select high
// - bank b halves when select high
// - output reset forces outputs, asynchronous; here pin is synchronized by two flops, then registered to outputs_held_out
// - pll multiply feedback over reference
`timescale 1ns/10ps
module pcs_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic mult_select_in,
  input wire logic bank_a_divide_select_in,
  input wire logic bank_b_divide_select_in,
  input wire logic output_reset_pin_in,
  output logic [9:0] feedback_divide_out,
  output logic [6:0] reference_divide_out,
  output logic bank_a_half_out,
  output logic bank_b_half_out,
  output logic outputs_held_out,
  output logic [7:0] divider_control_low_out,
  output logic [7:0] feedback_divide_code_out,
  pcs_link_if.slave link
);
  typedef enum logic [2:0] {
    PS_IDLE = 3'b000, PS_ADDR = 3'b001, PS_AACK = 3'b011, PS_WR = 3'b010,
    PS_WACK = 3'b110, PS_RD = 3'b111, PS_RACK = 3'b101
  } ps_state_t;
  ps_state_t st_q;
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] mr_s_q;
  logic [2:0] pin_s_q [2];
  logic scl_p_q;
  logic sda_p_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic full_q;
  logic [7:0] divider_control_low_q;
  logic [7:0] feedback_divide_code_q;
  logic [7:0] reserved_byte_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      pin_s_q[0] <= 3'h0;
      pin_s_q[1] <= 3'h0;
    end else if (en_in) begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
      pin_s_q[0] <= {mult_select_in, bank_a_divide_select_in, bank_b_divide_select_in};
      pin_s_q[1] <= pin_s_q[0];
    end
  end
  assign scl_rise = scl_s_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_s_q[1] & scl_p_q;
  assign start_c = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign stop_c = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= PS_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      divider_control_low_q <= pcs_pkg::CFG0_RESET;
      feedback_divide_code_q <= pcs_pkg::CFG1_RESET;
      reserved_byte_q <= pcs_pkg::CFG2_RESET;
      link.sda_s_out <= 1'b0;
      link.sda_s_oe_n <= 1'b1;
    end else if (en_in) begin
      if (stop_c) begin
        st_q <= PS_IDLE;
        link.sda_s_oe_n <= 1'b1;
      end else if (start_c) begin
        st_q <= PS_ADDR;
        bit_q <= 3'h0;
        cnt_q <= 3'h0;
        full_q <= 1'b0;
        link.sda_s_oe_n <= 1'b1;
      end else begin
        unique case (st_q)
          PS_IDLE: ;
          PS_ADDR, PS_WR: if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q[1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) full_q <= 1'b1;
          end else if (scl_fall && full_q) begin
            // byte whole only after eighth rise, not at the fall after start
            full_q <= 1'b0;
            if (st_q == PS_ADDR) begin
              if (sh_q[7:1] == pcs_pkg::SLAVE_ADDR) begin
                link.sda_s_oe_n <= 1'b0;
                st_q <= PS_AACK;
              end else begin
                st_q <= PS_IDLE;
              end
            end else begin
              link.sda_s_oe_n <= 1'b0;
              st_q <= PS_WACK;
              if (cnt_q == 3'(pcs_pkg::DUMMY_BYTES)) divider_control_low_q <= sh_q;
              if (cnt_q == 3'(pcs_pkg::DUMMY_BYTES + 1)) feedback_divide_code_q <= sh_q;
              if (cnt_q == 3'(pcs_pkg::DUMMY_BYTES + 2)) reserved_byte_q <= sh_q;
              if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
            end
          end
          PS_AACK: if (scl_fall) begin
            if (sh_q[0]) begin
              st_q <= PS_RD;
              link.sda_s_oe_n <= divider_control_low_q[7];
              sh_q <= {divider_control_low_q[6:0], 1'b0};
              bit_q <= 3'h1;
            end else begin
              link.sda_s_oe_n <= 1'b1;
              st_q <= PS_WR;
            end
          end
          PS_WACK: if (scl_fall) begin
            link.sda_s_oe_n <= 1'b1;
            st_q <= PS_WR;
          end
          PS_RD: if (scl_fall) begin
            if (bit_q == 3'h0) begin
              link.sda_s_oe_n <= 1'b1;
              st_q <= PS_RACK;
            end else begin
              link.sda_s_oe_n <= sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 3'h1;
            end
          end
          PS_RACK: if (scl_rise) begin
            if (sda_s_q[1]) begin
              st_q <= PS_IDLE;
            end else begin
              sh_q <= feedback_divide_code_q;
            end
          end else if (scl_fall) begin
            link.sda_s_oe_n <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
            bit_q <= 3'h1;
            st_q <= PS_RD;
          end
          default: st_q <= PS_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mr_s_q <= 2'h0;
      outputs_held_out <= 1'b0;
    end else if (en_in) begin
      mr_s_q <= {mr_s_q[0], output_reset_pin_in};
      outputs_held_out <= mr_s_q[1];
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      feedback_divide_out <= pcs_pkg::PIN_MULT_LOW;
      reference_divide_out <= 7'h01;
      bank_a_half_out <= 1'b0;
      bank_b_half_out <= 1'b0;
      divider_control_low_out <= pcs_pkg::CFG0_RESET;
      feedback_divide_code_out <= pcs_pkg::CFG1_RESET;
    end else if (en_in) begin
      divider_control_low_out <= divider_control_low_q;
      feedback_divide_code_out <= feedback_divide_code_q;
      bank_a_half_out <= pin_s_q[1][1];
      bank_b_half_out <= pin_s_q[1][0];
      if (divider_control_low_q[pcs_pkg::SEL_BIT]) begin
        feedback_divide_out <= ({2'h0, feedback_divide_code_q} + pcs_pkg::FB_OFFSET) << 1;
        reference_divide_out <= divider_control_low_q[pcs_pkg::BYP_BIT] ? 7'h01
          : {1'b0, divider_control_low_q[pcs_pkg::REF_MSB:0]} + pcs_pkg::REF_OFFSET;
      end else begin
        feedback_divide_out <= pin_s_q[1][2] ? pcs_pkg::PIN_MULT_HIGH : pcs_pkg::PIN_MULT_LOW;
        reference_divide_out <= 7'h01;
      end
    end
  end
endmodule : pcs_slave

// File: tb/pcs_props.sv
// pcs_props: wire-level checks of the two-wire link between master and slave
// assumes the signals of one pcs_link_if and a link half period of four clocks
`timescale 1ns/10ps
module pcs_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_m_out,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_out,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, sel_q, rd_q, rise, start;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] shift_q;
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  ////////////////////////////////////////////////////////////////////////////////
  // line history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bit and byte position within a frame
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (start) begin
      bit_q <= 4'h0;
      byte_q <= 3'h0;
    end else if (rise && bit_q == 4'h8) begin
      bit_q <= 4'h0;
      if (byte_q != 3'h7) begin
        byte_q <= byte_q + 3'h1;
      end
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      shift_q <= {shift_q[6:0], sda};
    end
  end
  // address match and direction of the frame
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (start) begin
      sel_q <= 1'b0;
    end else if (rise && bit_q == 4'h8 && byte_q == 3'h0) begin
      sel_q <= shift_q[7:1] == pcs_pkg::SLAVE_ADDR;
      rd_q <= shift_q[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_ack_rise; rise && bit_q == 4'h8; endsequence
  sequence s_data_rise; rise && bit_q != 4'h8; endsequence
  sequence s_stop; scl && scl_q && !sda_q && sda; endsequence
  property p_clock_master; scl_out == 1'b0 && sda_m_out == 1'b0; endproperty
  a_clock_master: assert property (p_clock_master) else $error("master drives high");
  property p_open_drain; sda_s_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("slave drives data high");
  property p_addr_ack;
    s_ack_rise ##0 byte_q == 3'h0 |-> sda_s_oe_n == (shift_q[7:1] != pcs_pkg::SLAVE_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_write_ack; s_ack_rise ##0 (byte_q != 3'h0 && sel_q && !rd_q) |-> !sda_s_oe_n;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write byte not acked");
  property p_read_ack_free; s_ack_rise ##0 (byte_q != 3'h0 && rd_q) |-> sda_s_oe_n; endproperty
  a_read_ack_free: assert property (p_read_ack_free) else $error("slave in master ack");
  property p_data_dir;
    s_data_rise ##0 !(sel_q && rd_q && byte_q != 3'h0) |-> sda_s_oe_n;
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("slave drives written bit");
  property p_unselected; !sel_q && byte_q != 3'h0 |-> sda_s_oe_n; endproperty
  a_unselected: assert property (p_unselected) else $error("unselected slave drives");
  property p_ack_hold;
    $rose(scl) && !sda_s_oe_n |-> !$past(sda_s_oe_n) ##0 (!sda_s_oe_n)[*4];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low not held over high");
  property p_no_change_high; $changed(sda_s_oe_n) |-> !scl; endproperty
  a_no_change_high: assert property (p_no_change_high) else $error("data moved, clock high");
  property p_stop_idle; s_stop |=> (sda_s_oe_n)[*4]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("slave busy after stop");
endmodule : pcs_props

// File: tb/pll_config_serial_slave_test.sv
// pll_config_serial_slave_test: master and slave on one link, checked at user ports
// assumes rtl/ and tb/pcs_props.sv compiled first
`timescale 1ns/10ps
module pll_config_serial_slave_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic en = 1'b1;
  logic start = 1'b0;
  logic rd = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [6:0] addr = 7'h00;
  logic [2:0] nb = 3'h1;
  logic [39:0] wd = 40'h0;
  logic busy, done, nack, ha, hb, held;
  logic [39:0] rdata;
  logic [9:0] fbd;
  logic [6:0] refd;
  logic [7:0] c0q, c1q;
  int error_cnt = 0;
  int checks = 0;
  always #50 clk_in = ~clk_in;
  pcs_link_if link ();
  pcs_master pcs_master_inst (.clk_in(clk_in), .rst_in(rst_in), .en_in(en), .start_in(start),
    .read_in(rd), .addr_in(addr), .nbytes_in(nb), .wdata_in(wd), .busy_out(busy),
    .done_out(done), .nack_out(nack), .rdata_out(rdata), .link(link.master));
  pcs_slave pcs_slave_inst (.clk_in(clk_in), .rst_in(rst_in), .en_in(en),
    .mult_select_in(pins[3]), .bank_a_divide_select_in(pins[2]),
    .bank_b_divide_select_in(pins[1]), .output_reset_pin_in(pins[0]),
    .feedback_divide_out(fbd), .reference_divide_out(refd), .bank_a_half_out(ha),
    .bank_b_half_out(hb), .outputs_held_out(held), .divider_control_low_out(c0q),
    .feedback_divide_code_out(c1q), .link(link.slave));
  pcs_props pcs_props_inst (.clk_in(clk_in), .rst_in(rst_in), .scl_out(link.scl_out),
    .scl_oe_n(link.scl_oe_n), .sda_m_out(link.sda_m_out), .sda_m_oe_n(link.sda_m_oe_n),
    .sda_s_out(link.sda_s_out), .sda_s_oe_n(link.sda_s_oe_n), .scl(link.scl),
    .sda(link.sda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic frame(input logic r, input logic [6:0] a, input logic [2:0] n,
    input logic [39:0] d);
    @(posedge clk_in);
    rd <= r;
    addr <= a;
    nb <= n;
    wd <= d;
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    #1;
    chk("busy", 40'h1, 40'(busy));
    for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk("frame done", 40'h1, 40'(done));
    chk("busy", 40'h0, 40'(busy));
  endtask : frame
  task automatic wr(input logic [7:0] c0, input logic [7:0] c1);
    logic [9:0] efb;
    logic [6:0] erf;
    efb = pins[3] ? pcs_pkg::PIN_MULT_HIGH : pcs_pkg::PIN_MULT_LOW;
    erf = 7'h01;
    if (c0[pcs_pkg::SEL_BIT]) begin
      efb = ({2'h0, c1} + pcs_pkg::FB_OFFSET) << 1;
      erf = c0[pcs_pkg::BYP_BIT] ? 7'h01 : {1'b0, c0[5:0]} + pcs_pkg::REF_OFFSET;
    end
    frame(1'b0, pcs_pkg::SLAVE_ADDR, 3'h7, {16'hC3FF, c0, c1, 8'h5A});
    repeat (6) @(posedge clk_in);
    #1;
    chk("nack", 40'h0, 40'(nack));
    chk("cfg0", 40'(c0), 40'(c0q));
    chk("cfg1", 40'(c1), 40'(c1q));
    chk("fb div", 40'(efb), 40'(fbd));
    chk("ref div", 40'(erf), 40'(refd));
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("fb div", 40'(pcs_pkg::PIN_MULT_LOW), 40'(fbd));
    chk("ref div", 40'h1, 40'(refd));
    chk("cfg0", 40'(pcs_pkg::CFG0_RESET), 40'(c0q));
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_in);
      pins <= 4'(k);
      repeat (6) @(posedge clk_in);
      #1;
      chk("pin mult", 40'(pins[3] ? pcs_pkg::PIN_MULT_HIGH : pcs_pkg::PIN_MULT_LOW), 40'(fbd));
      chk("bank a half", 40'(pins[2]), 40'(ha));
      chk("bank b half", 40'(pins[1]), 40'(hb));
      chk("outputs held", 40'(pins[0]), 40'(held));
    end
    @(posedge clk_in);
    en <= 1'b0;
    pins <= 4'h0;
    repeat (6) @(posedge clk_in);
    #1;
    chk("frozen bank a", 40'h1, 40'(ha));
    chk("frozen held", 40'h1, 40'(held));
    @(posedge clk_in);
    en <= 1'b1;
    @(posedge clk_in);
    pins <= 4'h8;
    wr(8'h45, 8'h20);
    wr(8'hC5, 8'hFF);
    frame(1'b1, pcs_pkg::SLAVE_ADDR, 3'h3, 40'h0);
    chk("read data", 40'hC5FFFF, 40'(rdata[23:0]));
    for (int b = 0; b < 7; b++) begin
      frame(1'b0, pcs_pkg::SLAVE_ADDR ^ 7'(1 << b), 3'h5, 40'h0000010203);
      chk("nack", 40'h1, 40'(nack));
      chk("cfg0 kept", 40'hC5, 40'(c0q));
    end
    wr(8'h05, 8'h10);
    tally_and_finish();
  end
endmodule : pll_config_serial_slave_test
